/* File: aop_fifo.sv */
// result buffer: parameterised FIFO with valid and ready on both sides
// assumes DEPTH is a power of two
module aop_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     in_valid,
	input  wire logic [WIDTH-1:0]         in_data,
	output logic                          in_ready,
	output logic                          out_valid,
	output logic [WIDTH-1:0]              out_data,
	input  wire logic                     out_ready,
	output logic [$clog2(DEPTH):0]        level
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
	} aop_fifo_s;

	aop_fifo_s        q;
	aop_fifo_s        d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic             push;
	logic             pop;

	// ****************************************************************
	// pointers
	// ****************************************************************
	assign in_ready  = (q.cnt != (AW+1)'(DEPTH));
	assign out_valid = (q.cnt != '0);
	assign out_data  = mem[q.rp];
	assign level     = q.cnt;
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_comb begin
		d = q;
		if (push) begin
			d.wp = q.wp + 1'b1;
		end
		if (pop) begin
			d.rp = q.rp + 1'b1;
		end
		d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// storage has no reset: out_data may show an unwritten word, but only while out_valid is low
	always_ff @(posedge pclk) begin
		if (push) begin
			mem[q.wp] <= in_data;
		end
	end

endmodule : aop_fifo

/* File: aop_host_model.sv */
// host model: takes master serial words and clocks slave serial reads
// assumes serial_result_output is the settled level of data pin 8, sampled on pclk
module aop_host_model (
	input  wire logic        pclk,
	input  wire logic        serial_result_output,
	input  wire logic        sclk_o,
	input  wire logic        sclk_oe,
	output logic             sclk_i,
	output logic             cs_n_i,
	output logic [15:0]      rx_word,
	output int               rx_cnt,
	output int               last_per
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] sh;
	logic        prev;
	int          nb;
	int          cyc;
	initial begin
		sclk_i = 1'b0;
		cs_n_i = 1'b1;
		rx_word = 16'h0000;
		rx_cnt = 0;
		nb = 0;
		cyc = 0;
		prev = 1'b0;
	end
	// ****************************************************************
	// master capture
	// ****************************************************************
	// a bit per rising device clock, msb first; period kept for the bench
	always @(posedge pclk) begin
		cyc++;
		if (sclk_oe && sclk_o && !prev) begin
			sh = {sh[14:0], serial_result_output};
			nb++;
			last_per = cyc;
			cyc = 0;
			if (nb == 16) begin
				rx_word = sh;
				rx_cnt++;
				nb = 0;
			end
		end
		prev = sclk_o;
	end
	// ****************************************************************
	// slave read
	// ****************************************************************
	// clock idles low outside frames and runs at pclk/16, eight pclk cycles high and eight low
	task automatic slave_read(output logic [15:0] w);
		w = 16'h0000;
		cs_n_i <= 1'b0;
		repeat (8) @(posedge pclk);
		for (int i = 0; i < 16; i++) begin
			w = {w[14:0], serial_result_output};
			sclk_i <= 1'b1;
			repeat (8) @(posedge pclk);
			sclk_i <= 1'b0;
			repeat (8) @(posedge pclk);
		end
		cs_n_i <= 1'b1;
	endtask : slave_read
endmodule : aop_host_model

/* File: aop_pkg.sv */
// types shared by the result output port block
// assumes aop_regs.svh is on the include path
package aop_pkg;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0] {AOP_WARP, AOP_NORMAL, AOP_IMPULSE} aop_speed_e;

	typedef enum logic [1:0] {AOP_SER_IDLE, AOP_SER_MSHIFT, AOP_SER_SLAVE} aop_ser_e;

	// pin straps, all asynchronous to pclk
	typedef struct packed {
		logic byte_order;
		logic code_format;
		logic fast_mode;
		logic low_power_mode;
		logic serial_sel;
	} aop_strap_s;

	typedef struct packed {
		logic [10:0] sy1;
		logic [10:0] sy2;
		logic        sclk_prev;
		logic        cs_prev;
		logic        busy_prev;
		aop_ser_e    st;
		logic [15:0] sh;
		logic [3:0]  bits;
		logic [4:0]  ph;
		logic [4:0]  per;
		logic        sclk;
		logic [15:0] dout;
		logic [15:0] doe;
		logic        sclk_oe;
		aop_speed_e  mode;
		logic        en;
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} aop_state_s;

endpackage : aop_pkg

/* File: aop_port.sv */
// output port of the converter: parallel bus or serial port chosen by straps,
// with an APB slave for enable and status
// assumes results arrive as straight binary words on pclk from the converter core
//
// Added by the designer: the APB slave port and the address map.
`include "aop_regs.svh"

// Behaviour
// RULE1: byte order low: low byte on d[7:0], high byte on d[15:8].
// RULE2: byte order high: bytes swapped on the parallel bus.
// RULE3: code format high gives straight binary; low inverts the msb.
// RULE4: fast high, low power low selects maximum throughput; host keeps minimum rate.
// RULE5: fast low keeps full accuracy with no minimum conversion rate.
// RULE6: low power high, fast low selects reduced power mode.
// RULE7: serial select low uses parallel port; high enables serial port pins.
// RULE8: bits 0 and 1 driven in parallel mode, released in serial mode.
// RULE9: dual-purpose pins carry result bits 2, 3, 4 in parallel mode.
// RULE10: master read-after-convert lets host slow the clock by divider pins.
// RULE11: other serial modes release the divider pins and ignore them.
// RULE12: clock source low: device drives its own serial clock.
// RULE13: clock source high: host clock shifts data only while chip select low.
// RULE14: divider codes 00..11 give 25, 50, 100, 200 ns least periods.
// RULE15: read mode high shifts previous result during conversion, else after.
// RULE16: serial result leaves msb first with the selected coding.
// RULE17: both mode straps low is normal mode; both high unsupported.
// RULE18: host keeps straps stable except while the converter is idle.
module aop_port
	import aop_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        res_valid,
	input  wire logic [15:0] res_data,
	output logic             res_ready,
	input  wire logic        conv_busy,
	input  wire aop_strap_s  strap,
	input  wire logic [15:0] d_i,
	output logic [15:0]      d_o,
	output logic [15:0]      d_oe,
	input  wire logic        sclk_i,
	output logic             sclk_o,
	output logic             sclk_oe,
	input  wire logic        cs_n_i,
	output aop_speed_e       conv_mode
);

	// ****************************************************************
	// functions
	// ****************************************************************
	function automatic logic [15:0] fmt_word(input logic [15:0] w, input logic straight);
		fmt_word = {w[15] ^ ~straight, w[14:0]};
	endfunction : fmt_word

	function automatic logic [4:0] per_of(input logic [1:0] code);
		case (code)
			2'b00:   per_of = 5'(`AOP_NS2CYC(`AOP_SCLK_P0_NS));
			2'b01:   per_of = 5'(`AOP_NS2CYC(`AOP_SCLK_P1_NS));
			2'b10:   per_of = 5'(`AOP_NS2CYC(`AOP_SCLK_P2_NS));
			default: per_of = 5'(`AOP_NS2CYC(`AOP_SCLK_P3_NS));
		endcase
	endfunction : per_of

	// ****************************************************************
	// state and buffer
	// ****************************************************************
	aop_state_s  q;
	aop_state_s  d;
	logic        f_valid;
	logic [15:0] f_data;
	logic        f_pop;
	logic [4:0]  f_level;
	logic        s_bo;
	logic        s_cf;
	logic        s_fast;
	logic        s_lp;
	logic        s_ser;
	logic [1:0]  s_div;
	logic        s_src;
	logic        s_rd;
	logic        s_sclk;
	logic        s_cs_n;
	logic        rac;
	logic [15:0] f_fmt;
	logic        apb_acc;

	aop_fifo #(
		.WIDTH (`AOP_WORD_W),
		.DEPTH (`AOP_FIFO_DEPTH)
	) u_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (res_valid),
		.in_data   (res_data),
		.in_ready  (res_ready),
		.out_valid (f_valid),
		.out_data  (f_data),
		.out_ready (f_pop),
		.level     (f_level)
	);

	// only the second synchroniser stage is read
	assign s_bo    = q.sy2[0];
	assign s_cf    = q.sy2[1];
	assign s_fast  = q.sy2[2];
	assign s_lp    = q.sy2[3];
	assign s_ser   = q.sy2[4];
	assign s_div   = q.sy2[6:5];
	assign s_src   = q.sy2[7];
	assign s_rd    = q.sy2[8];
	assign s_sclk  = q.sy2[9];
	assign s_cs_n  = q.sy2[10];
	assign rac     = s_ser & ~s_src & ~s_rd;
	assign f_fmt   = fmt_word(f_data, s_cf); // see RULE3 see RULE16
	assign apb_acc = psel & penable;

	assign pready    = q.pready;
	assign prdata    = q.prdata;
	assign pslverr   = q.pslverr;
	assign d_o       = q.dout;
	assign d_oe      = q.doe;
	assign sclk_o    = q.sclk;
	assign sclk_oe   = q.sclk_oe;
	assign conv_mode = q.mode;

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		d           = q;
		f_pop       = 1'b0;
		d.sy1       = {cs_n_i, sclk_i, d_i[7], d_i[4], d_i[3], d_i[2],
		               strap.serial_sel, strap.low_power_mode, strap.fast_mode,
		               strap.code_format, strap.byte_order};
		d.sy2       = q.sy1;
		d.sclk_prev = s_sclk;
		d.cs_prev   = s_cs_n;
		d.busy_prev = conv_busy;

		// speed mode to the converter core; both high falls back to normal
		if (s_fast && !s_lp) begin
			d.mode = AOP_WARP; // see RULE4
		end else if (s_lp && !s_fast) begin
			d.mode = AOP_IMPULSE; // see RULE6
		end else begin
			d.mode = AOP_NORMAL; // see RULE5 see RULE17
		end

		// apb: one wait state, write lands on the edge that samples pready
		d.pready  = apb_acc & ~q.pready;
		d.pslverr = 1'b0;
		if (apb_acc && !q.pready) begin
			d.prdata = 32'h00000000;
			case (paddr)
				`AOP_CTRL_OFS: begin
					d.prdata[`AOP_CTRL_EN_BIT] = q.en;
				end
				`AOP_STATUS_OFS: begin
					d.prdata[`AOP_ST_SERIAL_BIT]           = s_ser;
					d.prdata[`AOP_ST_SLAVE_BIT]            = s_src;
					d.prdata[`AOP_ST_RDDUR_BIT]            = s_rd;
					d.prdata[`AOP_ST_MODE_LSB +: 2]        = q.mode;
					d.prdata[`AOP_ST_UNSUP_BIT]            = s_fast & s_lp;
					d.prdata[`AOP_ST_BUSY_BIT]             = (q.st != AOP_SER_IDLE);
					d.prdata[`AOP_ST_LEVEL_LSB +: 5]       = f_level;
					d.prdata[`AOP_ST_DIV_LSB +: 2]         = rac ? s_div : 2'b00;
				end
				default: begin
					d.pslverr = 1'b1;
				end
			endcase
		end
		if (apb_acc && q.pready && pwrite && paddr == `AOP_CTRL_OFS) begin
			d.en = pwdata[`AOP_CTRL_EN_BIT];
		end

		// serial engine
		case (q.st)
			AOP_SER_IDLE: begin
				d.sclk = 1'b0;
				if (q.en && s_ser && !s_src && f_valid &&
				    (s_rd ? (conv_busy && !q.busy_prev) : !conv_busy)) begin // see RULE15
					f_pop  = 1'b1;
					d.sh   = f_fmt; // see RULE16
					d.bits = 4'h0;
					d.ph   = 5'h00;
					d.per  = per_of(rac ? s_div : 2'b00); // see RULE10 see RULE11 see RULE14
					d.st   = AOP_SER_MSHIFT;
				end else if (q.en && s_ser && s_src && !s_cs_n && q.cs_prev) begin
					f_pop = f_valid;
					d.sh  = f_valid ? f_fmt : 16'h0000;
					d.st  = AOP_SER_SLAVE;
				end
			end
			AOP_SER_MSHIFT: begin
				d.ph = (q.ph == q.per - 5'h01) ? 5'h00 : q.ph + 5'h01;
				if (q.ph == 5'h00) begin
					d.sclk = 1'b1; // see RULE12
				end else if (q.ph == q.per - (q.per >> 1)) begin
					d.sclk = 1'b0;
					d.sh   = {q.sh[14:0], 1'b0};
					d.bits = q.bits + 4'h1;
					if (q.bits == 4'hF) begin
						d.st = AOP_SER_IDLE;
					end
				end
			end
			AOP_SER_SLAVE: begin
				// host clock is sampled on pclk, so it must stay well below pclk/4
				if (s_cs_n) begin
					d.st = AOP_SER_IDLE;
				end else if (s_sclk && !q.sclk_prev) begin
					d.sh = {q.sh[14:0], s_rd}; // see RULE13
				end
			end
			default: begin
				d.st = AOP_SER_IDLE;
			end
		endcase

		// pins
		if (!s_ser) begin
			d.st      = AOP_SER_IDLE;
			d.sclk    = 1'b0;
			d.sclk_oe = 1'b0;
			d.doe     = q.en ? 16'hFFFF : 16'h0000; // see RULE7 see RULE8 see RULE9
			if (q.en && f_valid) begin
				f_pop  = 1'b1;
				d.dout = s_bo ? {f_fmt[7:0], f_fmt[15:8]} : f_fmt; // see RULE1 see RULE2
			end
		end else begin
			// serial: only the data output pin drives; divider pins stay released
			d.doe     = 16'h0000; // see RULE8 see RULE11
			d.doe[8]  = q.en & (~s_src | ~s_cs_n); // see RULE13
			d.dout    = 16'h0000;
			d.dout[8] = d.sh[15];
			d.sclk_oe = q.en & ~s_src; // see RULE12
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q       <= '0;
			q.en    <= 1'b1;
			q.mode  <= AOP_NORMAL;
			q.sy1   <= 11'h400;
			q.sy2   <= 11'h400;
			q.cs_prev <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	logic [4:0] gap_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_q <= 5'h00;
		end else if (d.sclk && !q.sclk) begin
			gap_q <= 5'h01;
		end else begin
			gap_q <= gap_q + 5'h01;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence seq_par_pop;
		!s_ser && f_pop;
	endsequence

	sequence seq_master_load;
		q.st == AOP_SER_IDLE && f_pop && s_ser && !s_src;
	endsequence

	chk_par_byte_order: assert property (seq_par_pop |=> // see RULE1 see RULE2
		d_o == ($past(s_bo) ? {$past(f_fmt[7:0]), $past(f_fmt[15:8])} : $past(f_fmt)))
		else $error("parallel byte order wrong");
	chk_code_msb: assert property (seq_par_pop ##0 !s_bo |=> // see RULE3
		d_o[15] == ($past(f_data[15]) ^ ~$past(s_cf)))
		else $error("msb coding wrong");
	chk_low_bits_hiz: assert property ($past(s_ser) && s_ser |-> d_oe[1:0] == 2'b00) // see RULE8
		else $error("bits 0 and 1 driven in serial mode");
	chk_div_released: assert property (s_ser ##1 s_ser |-> d_oe[7:2] == 6'h00) // see RULE11
		else $error("divider pins driven in serial mode");
	chk_master_clk_out: assert property (q.st == AOP_SER_MSHIFT && q.en && $past(s_ser) && // see RULE12
		!$past(s_src) |-> sclk_oe)
		else $error("master clock not driven");
	chk_slave_no_clk: assert property (q.st == AOP_SER_SLAVE && $past(s_src) |-> !sclk_oe) // see RULE13
		else $error("slave mode drives clock");
	chk_sclk_period: assert property (q.st == AOP_SER_MSHIFT && q.bits != 4'h0 && // see RULE14
		d.sclk && !q.sclk |-> gap_q == q.per)
		else $error("serial clock period wrong");
	chk_master_msb: assert property (seq_master_load |=> d_o[8] == $past(f_fmt[15])) // see RULE16
		else $error("first serial bit is not msb");
	chk_rac_waits: assert property (q.st == AOP_SER_IDLE && s_ser && !s_src && !s_rd && conv_busy
		|=> q.st != AOP_SER_MSHIFT) // see RULE15
		else $error("read after convert started during conversion");
	chk_mode_map: assert property (s_fast && !s_lp ##1 s_fast && !s_lp |-> conv_mode == AOP_WARP) // see RULE4
		else $error("warp mode not selected");
	chk_impulse_map: assert property (s_lp && !s_fast ##1 s_lp && !s_fast |-> conv_mode == AOP_IMPULSE) // see RULE6
		else $error("reduced power mode not selected");

endmodule : aop_port

/* File: aop_regs.svh */
// register offsets, field positions, reset values and timing counts of the
// result output port block
// assumes a 100 MHz pclk and 32-bit APB data
`ifndef AOP_REGS_SVH
`define AOP_REGS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define AOP_CTRL_OFS        12'h000
`define AOP_STATUS_OFS      12'h004
`define AOP_CTRL_RST        32'h00000001
`define AOP_CTRL_EN_BIT     0

`define AOP_ST_SERIAL_BIT   0
`define AOP_ST_SLAVE_BIT    1
`define AOP_ST_RDDUR_BIT    2
`define AOP_ST_MODE_LSB     3
`define AOP_ST_UNSUP_BIT    5
`define AOP_ST_BUSY_BIT     6
`define AOP_ST_LEVEL_LSB    8
`define AOP_ST_DIV_LSB      14

// ****************************************************************
// data path sizes
// ****************************************************************
`define AOP_WORD_W          16
`define AOP_FIFO_DEPTH      16

// ****************************************************************
// timing
// ****************************************************************
`define AOP_PCLK_NS         10
`define AOP_SCLK_P0_NS      25
`define AOP_SCLK_P1_NS      50
`define AOP_SCLK_P2_NS      100
`define AOP_SCLK_P3_NS      200
// least periods, so cycle counts round up
`define AOP_NS2CYC(ns)      (((ns) + `AOP_PCLK_NS - 1) / `AOP_PCLK_NS)

`endif

/* File: testbench.sv */
// self-checking bench of the result output port
// assumes aop_regs.svh on the include path and the host model beside it
`include "aop_regs.svh"
module testbench
	import aop_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        res_valid, res_ready, conv_busy, sclk_i, sclk_o, sclk_oe, cs_n_i;
	logic [15:0] res_data, tb_d, d_pin, d_o, d_oe, rx_word;
	aop_strap_s  strap;
	aop_speed_e  conv_mode;
	int          rx_cnt, last_per, error_cnt, samples_checked, cyc_cnt;
	int          per_tab[4] = '{`AOP_NS2CYC(`AOP_SCLK_P0_NS), `AOP_NS2CYC(`AOP_SCLK_P1_NS),
		`AOP_NS2CYC(`AOP_SCLK_P2_NS), `AOP_NS2CYC(`AOP_SCLK_P3_NS)};
	// released pins show the bench level
	assign d_pin = (d_o & d_oe) | (tb_d & ~d_oe);
	aop_port uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .res_valid(res_valid), .res_data(res_data), .res_ready(res_ready),
		.conv_busy(conv_busy), .strap(strap), .d_i(d_pin), .d_o(d_o), .d_oe(d_oe),
		.sclk_i(sclk_i), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .cs_n_i(cs_n_i),
		.conv_mode(conv_mode));
	aop_host_model host (.pclk(pclk), .serial_result_output(d_pin[8]), .sclk_o(sclk_o), .sclk_oe(sclk_oe),
		.sclk_i(sclk_i), .cs_n_i(cs_n_i), .rx_word(rx_word), .rx_cnt(rx_cnt),
		.last_per(last_per));
	always #5 pclk = ~pclk;
	// ****************************************************************
	// helpers
	// ****************************************************************
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : wrap_up
	always @(posedge pclk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			error_cnt++;
			wrap_up();
		end
	end
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask : tick
	// request held until pready is seen high at an edge
	// no local limit: only the bench timeout ends a wait
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic push(input logic [15:0] w);
		res_valid <= 1'b1;
		res_data <= w;
		do begin
			@(posedge pclk);
		end while (res_ready !== 1'b1);
		res_valid <= 1'b0;
		@(posedge pclk);
	endtask : push
	function automatic logic [15:0] exp_par(logic [15:0] w, logic bo, logic cf);
		logic [15:0] v;
		v = cf ? w : {~w[15], w[14:0]};
		return bo ? {v[7:0], v[15:8]} : v;
	endfunction : exp_par
	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_regs();
		apb(1'b0, `AOP_CTRL_OFS, 32'h0);
		chk("ctrl", rd, `AOP_CTRL_RST);
		apb(1'b0, 12'h008, 32'h0);
		chk("unmapped rd", {rd[30:0], err}, 32'h00000001);
		apb(1'b1, 12'h00C, 32'hFFFFFFFF);
		chk("unmapped wr", 32'(err), 32'h1);
	endtask : t_regs
	task automatic t_par();
		for (int i = 0; i < 4; i++) begin
			strap.byte_order <= i[1];
			strap.code_format <= i[0];
			tick(5);
			push(16'h9A3C);
			tick(4);
			chk("d_o", 32'(d_o), 32'(exp_par(16'h9A3C, i[1], i[0])));
			chk("d_oe", 32'(d_oe), 32'h0000FFFF);
		end
	endtask : t_par
	task automatic t_modes();
		aop_speed_e m[4] = '{AOP_NORMAL, AOP_IMPULSE, AOP_WARP, AOP_NORMAL};
		for (int i = 0; i < 4; i++) begin
			strap.fast_mode <= i[1];
			strap.low_power_mode <= i[0];
			tick(5);
			chk("mode", 32'(conv_mode), 32'(m[i]));
		end
	endtask : t_modes
	// buffer fills while disabled, then drains in order, one word a cycle
	task automatic t_fifo();
		int idx;
		strap.byte_order <= 1'b0;
		strap.code_format <= 1'b1;
		apb(1'b1, `AOP_CTRL_OFS, 32'h0);
		for (int i = 0; i < 16; i++) push(16'h1000 + 16'(i));
		tick(2);
		chk("res_ready", 32'(res_ready), 32'h0);
		apb(1'b0, `AOP_STATUS_OFS, 32'h0);
		chk("level", 32'(rd[12:8]), 32'h10);
		apb(1'b1, `AOP_CTRL_OFS, 32'h1);
		idx = 0;
		repeat (24) begin
			@(posedge pclk);
			if (d_o === 16'h1000 + 16'(idx)) idx++;
		end
		chk("order", 32'(idx), 32'h10);
	endtask : t_fifo
	task automatic t_master(input logic [1:0] code, input logic rdc);
		int n0, k;
		strap.serial_sel <= 1'b1;
		strap.code_format <= 1'b0;
		// after convert: a running conversion holds the word; during: it waits for a start
		conv_busy <= ~rdc;
		tb_d <= {8'h01, rdc, 2'b00, 1'b0, code, 2'b00};
		tick(10);
		n0 = rx_cnt;
		push(16'hB2E1);
		tick(40);
		chk("early", 32'(rx_cnt - n0), 32'h0);
		conv_busy <= 1'b1;
		tick(2);
		conv_busy <= 1'b0;
		k = 0;
		while (rx_cnt == n0 && k < 1000) begin
			tick(1);
			k++;
		end
		chk("words", 32'(rx_cnt - n0), 32'h1);
		chk("word", 32'(rx_word), 32'h000032E1);
		chk("period", 32'(last_per), 32'(rdc ? per_tab[0] : per_tab[code]));
		chk("d_oe", 32'(d_oe), 32'h00000100);
		chk("sclk_oe", 32'(sclk_oe), 32'h1);
		apb(1'b0, `AOP_STATUS_OFS, 32'h0);
		chk("div", 32'(rd[15:14]), 32'(rdc ? 2'b00 : code));
	endtask : t_master
	task automatic t_slave();
		logic [15:0] got;
		tb_d <= 16'h0110;
		strap.code_format <= 1'b1;
		tick(10);
		push(16'h6D29);
		tick(4);
		chk("sclk_oe", 32'(sclk_oe), 32'h0);
		host.slave_read(got);
		chk("slave word", 32'(got), 32'h00006D29);
	endtask : t_slave
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, res_valid, conv_busy} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		res_data = 16'h0000;
		strap = '0;
		tb_d = 16'h0000;
		error_cnt = 0;
		samples_checked = 0;
		cyc_cnt = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		tick(3);
		t_regs();
		t_modes();
		t_par();
		t_fifo();
		for (int c = 0; c < 4; c++) t_master(c[1:0], 1'b0);
		t_master(2'b11, 1'b1);
		t_slave();
		wrap_up();
	end
endmodule : testbench
